// file: pkg/ump_defs.svh
// Register offsets, field positions, reset values and the data bit count of the modem-pin serial port.
`ifndef UMP_DEFS_SVH
`define UMP_DEFS_SVH

`define UMP_REG_DATA 3'h0
`define UMP_REG_INT_EN 3'h1
`define UMP_REG_LINE_CTRL 3'h2
`define UMP_REG_MODEM_CTRL 3'h3
`define UMP_REG_LINE_STAT 3'h4
`define UMP_REG_MODEM_STAT 3'h5
`define UMP_REG_DIVISOR 3'h6

`define UMP_MC_DTR 0
`define UMP_MC_RTS 1
`define UMP_MC_LOOP 4
`define UMP_MS_DCTS 0
`define UMP_MS_DDSR 1
`define UMP_MS_CTS 4
`define UMP_MS_DSR 5
`define UMP_IE_RX 0
`define UMP_IE_MODEM 3
`define UMP_LC_TX_EN 0
`define UMP_LS_READY 0
`define UMP_LS_OVERRUN 1
`define UMP_LS_THR_EMPTY 5
`define UMP_LS_TX_IDLE 6

`define UMP_INT_EN_RST 8'h00
`define UMP_LINE_CTRL_RST 1'b1
`define UMP_DIVISOR_RST 16'h00ae

`define UMP_DATA_BITS 8
`endif

// file: pkg/ump_pkg.sv
// Types shared by the modem-pin serial port.
package ump_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ump_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ump_rx_state_t;
	typedef struct packed {
		logic loop;
		logic rts;
		logic dtr;
	} ump_modem_ctrl_t;
	typedef struct packed {
		logic dsr;
		logic cts;
		logic ddsr;
		logic dcts;
	} ump_modem_stat_t;
endpackage

// file: rtl/ump_uart_core.sv
// Serial port with modem-control outputs, modem-status inputs and an Avalon-MM register slave.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "ump_defs.svh"
module ump_uart_core
	import ump_pkg::*;
#(
	parameter int DIV_W = 16
)
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic [2:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic rxd_i,
	output logic txd_o,
	output logic rts_n_o,
	output logic dtr_n_o,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	output logic irq_o
);

	// A pin level is accepted once the second and third stages agree.
	function automatic logic settle(input logic s2, input logic s3, input logic cur);
		settle = (s2 == s3) ? s3 : cur;
	endfunction

	logic req, fin, tx_en, rx_pin, cts_pin_n, dsr_pin_n, dcts, ddsr, thr_full, tx_load, tx_bit;
	logic rx_done, rx_ready, overrun, rx_line, next_cts_n, next_dsr_n, rd_data, rd_line, rd_modem;
	logic [31:0] rd_val;
	logic [7:0] int_en, thr, tx_sh, rx_sh, rbr;
	logic [2:0] rx_sync, cts_sync, dsr_sync, tx_idx, rx_idx;
	logic [DIV_W-1:0] divisor, tx_cnt, rx_cnt;
	ump_modem_ctrl_t modem_control_reg;
	ump_modem_stat_t modem_status_reg;
	ump_tx_state_t tx_st;
	ump_rx_state_t rx_st;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: every access is answered on the second cycle it is held.

	assign req = avs_read_i | avs_write_i;
	assign fin = req & ~avs_waitrequest_o;
	assign rd_data = fin & avs_read_i & (avs_address_i == `UMP_REG_DATA);
	assign rd_line = fin & avs_read_i & (avs_address_i == `UMP_REG_LINE_STAT);
	assign rd_modem = fin & avs_read_i & (avs_address_i == `UMP_REG_MODEM_STAT);

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			avs_waitrequest_o <= 1'b1;
		else if (fin)
			avs_waitrequest_o <= 1'b1;
		else if (req)
			avs_waitrequest_o <= 1'b0;
	end

	assign modem_status_reg = '{dsr: ~dsr_pin_n, cts: ~cts_pin_n, ddsr: ddsr, dcts: dcts};

	always_comb
	begin
		rd_val = 32'h0;
		case (avs_address_i)
			`UMP_REG_DATA: rd_val[7:0] = rbr;
			`UMP_REG_INT_EN: rd_val[7:0] = int_en;
			`UMP_REG_LINE_CTRL: rd_val[`UMP_LC_TX_EN] = tx_en;
			`UMP_REG_MODEM_CTRL:
			begin
				rd_val[`UMP_MC_DTR] = modem_control_reg.dtr;
				rd_val[`UMP_MC_RTS] = modem_control_reg.rts;
				rd_val[`UMP_MC_LOOP] = modem_control_reg.loop;
			end
			`UMP_REG_LINE_STAT:
			begin
				rd_val[`UMP_LS_READY] = rx_ready;
				rd_val[`UMP_LS_OVERRUN] = overrun;
				rd_val[`UMP_LS_THR_EMPTY] = ~thr_full;
				rd_val[`UMP_LS_TX_IDLE] = (tx_st == TX_IDLE);
			end
			`UMP_REG_MODEM_STAT:
			begin
				rd_val[`UMP_MS_DCTS] = modem_status_reg.dcts;
				rd_val[`UMP_MS_DDSR] = modem_status_reg.ddsr;
				rd_val[`UMP_MS_CTS] = modem_status_reg.cts;
				rd_val[`UMP_MS_DSR] = modem_status_reg.dsr;
			end
			`UMP_REG_DIVISOR: rd_val[DIV_W-1:0] = divisor;
			default: rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			avs_readdata_o <= 32'h0;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= rd_val;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			int_en <= `UMP_INT_EN_RST;
			tx_en <= `UMP_LINE_CTRL_RST;
			modem_control_reg <= '0;
			divisor <= DIV_W'(`UMP_DIVISOR_RST);
		end
		else if (fin && avs_write_i)
		begin
			case (avs_address_i)
				`UMP_REG_INT_EN: int_en <= avs_writedata_i[7:0];
				`UMP_REG_LINE_CTRL: tx_en <= avs_writedata_i[`UMP_LC_TX_EN];
				`UMP_REG_MODEM_CTRL:
				begin
					modem_control_reg.dtr <= avs_writedata_i[`UMP_MC_DTR];
					modem_control_reg.rts <= avs_writedata_i[`UMP_MC_RTS];
					modem_control_reg.loop <= avs_writedata_i[`UMP_MC_LOOP];
				end
				`UMP_REG_DIVISOR: divisor <= avs_writedata_i[DIV_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and modem status.

	assign next_cts_n = settle(cts_sync[1], cts_sync[2], cts_pin_n);
	assign next_dsr_n = settle(dsr_sync[1], dsr_sync[2], dsr_pin_n);

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rx_sync <= 3'h7;
			cts_sync <= 3'h7;
			dsr_sync <= 3'h7;
			rx_pin <= 1'b1;
			cts_pin_n <= 1'b1;
			dsr_pin_n <= 1'b1;
		end
		else
		begin
			rx_sync <= {rx_sync[1:0], rxd_i};
			cts_sync <= {cts_sync[1:0], cts_n_i};
			dsr_sync <= {dsr_sync[1:0], dsr_n_i};
			rx_pin <= settle(rx_sync[1], rx_sync[2], rx_pin);
			cts_pin_n <= next_cts_n;
			dsr_pin_n <= next_dsr_n;
		end
	end

	// A change arriving in the cycle of the clearing read still sets the flag.
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			dcts <= 1'b0;
			ddsr <= 1'b0;
		end
		else
		begin
			if (next_cts_n != cts_pin_n)
				dcts <= 1'b1;
			else if (rd_modem)
				dcts <= 1'b0;
			if (next_dsr_n != dsr_pin_n)
				ddsr <= 1'b1;
			else if (rd_modem)
				ddsr <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rts_n_o <= 1'b1;
			dtr_n_o <= 1'b1;
			irq_o <= 1'b0;
		end
		else
		begin
			rts_n_o <= ~modem_control_reg.rts;
			dtr_n_o <= ~modem_control_reg.dtr;
			irq_o <= (int_en[`UMP_IE_MODEM] & (dcts | ddsr)) | (int_en[`UMP_IE_RX] & rx_ready);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter. One bit lasts divisor cycles; a write while the holding byte is full is dropped.

	assign tx_load = (tx_st == TX_IDLE) & thr_full & tx_en;

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			thr <= 8'h00;
			thr_full <= 1'b0;
		end
		else if (fin && avs_write_i && avs_address_i == `UMP_REG_DATA && !thr_full)
		begin
			thr <= avs_writedata_i[7:0];
			thr_full <= 1'b1;
		end
		else if (tx_load)
			thr_full <= 1'b0;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tx_st <= TX_IDLE;
			tx_cnt <= '0;
			tx_idx <= 3'h0;
			tx_sh <= 8'h00;
			tx_bit <= 1'b1;
		end
		else if (tx_st == TX_IDLE)
		begin
			tx_bit <= 1'b1;
			if (tx_load)
			begin
				tx_sh <= thr;
				tx_st <= TX_START;
				tx_cnt <= divisor - 1'b1;
				tx_bit <= 1'b0;
			end
		end
		else if (tx_cnt != '0)
			tx_cnt <= tx_cnt - 1'b1;
		else
		begin
			tx_cnt <= divisor - 1'b1;
			case (tx_st)
				TX_START:
				begin
					tx_bit <= tx_sh[0];
					tx_idx <= 3'h0;
					tx_st <= TX_DATA;
				end
				TX_DATA:
				begin
					if (tx_idx == 3'(`UMP_DATA_BITS - 1))
					begin
						tx_bit <= 1'b1;
						tx_st <= TX_STOP;
					end
					else
					begin
						tx_sh <= tx_sh >> 1;
						tx_bit <= tx_sh[1];
						tx_idx <= tx_idx + 1'b1;
					end
				end
				TX_STOP: tx_st <= TX_IDLE;
				default: tx_st <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			txd_o <= 1'b1;
		else
			txd_o <= (tx_en && !modem_control_reg.loop && tx_st != TX_IDLE) ? tx_bit : 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receiver. The start bit is checked at its middle, so each later bit is sampled mid-cell.

	assign rx_line = modem_control_reg.loop ? tx_bit : rx_pin;

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rx_st <= RX_IDLE;
			rx_cnt <= '0;
			rx_idx <= 3'h0;
			rx_sh <= 8'h00;
			rx_done <= 1'b0;
		end
		else
		begin
			rx_done <= 1'b0;
			if (rx_st == RX_IDLE)
			begin
				if (!rx_line)
				begin
					rx_st <= RX_START;
					rx_cnt <= divisor >> 1;
				end
			end
			else if (rx_cnt != '0)
				rx_cnt <= rx_cnt - 1'b1;
			else
			begin
				rx_cnt <= divisor - 1'b1;
				case (rx_st)
					RX_START:
					begin
						rx_idx <= 3'h0;
						rx_st <= rx_line ? RX_IDLE : RX_DATA;
					end
					RX_DATA:
					begin
						rx_sh <= {rx_line, rx_sh[7:1]};
						rx_idx <= rx_idx + 1'b1;
						if (rx_idx == 3'(`UMP_DATA_BITS - 1))
							rx_st <= RX_STOP;
					end
					RX_STOP:
					begin
						rx_done <= rx_line;
						rx_st <= RX_IDLE;
					end
					default: rx_st <= RX_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rbr <= 8'h00;
			rx_ready <= 1'b0;
			overrun <= 1'b0;
		end
		else
		begin
			if (rx_done)
			begin
				rbr <= rx_sh;
				rx_ready <= 1'b1;
			end
			else if (rd_data)
				rx_ready <= 1'b0;
			if (rx_done && rx_ready)
				overrun <= 1'b1;
			else if (rd_line)
				overrun <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_req_seen;
		req && avs_waitrequest_o;
	endsequence
	sequence s_msr_read;
		avs_read_i && avs_waitrequest_o && avs_address_i == `UMP_REG_MODEM_STAT;
	endsequence

	chk_bus_answer: assert property (s_req_seen |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus access not answered in one wait cycle");
	chk_rts_level: assert property (rts_n_o == !$past(modem_control_reg.rts))
		else $error("request-to-send pin does not follow its control bit");
	chk_dtr_level: assert property (dtr_n_o == !$past(modem_control_reg.dtr))
		else $error("terminal-ready pin does not follow its control bit");
	chk_txd_forced: assert property ((!tx_en || modem_control_reg.loop || tx_st == TX_IDLE) |=> txd_o)
		else $error("transmit pin not held high");
	chk_loop_ignore: assert property ((modem_control_reg.loop && $stable(modem_control_reg.loop) && $changed(rx_pin)
		&& $stable(tx_bit)) |-> $stable(rx_line))
		else $error("receive pin reached the receiver in loopback");
	chk_cts_level: assert property (s_msr_read |=> avs_readdata_o[`UMP_MS_CTS] == !$past(cts_pin_n))
		else $error("clear-to-send status bit wrong");
	chk_dsr_level: assert property (s_msr_read |=> avs_readdata_o[`UMP_MS_DSR] == !$past(dsr_pin_n))
		else $error("data-set-ready status bit wrong");
	chk_cts_delta: assert property ($changed(cts_pin_n) |-> dcts)
		else $error("clear-to-send change flag not set");
	chk_dsr_delta: assert property ($changed(dsr_pin_n) |-> ddsr)
		else $error("data-set-ready change flag not set");
	chk_modem_irq: assert property ((int_en[`UMP_IE_MODEM] && (dcts || ddsr)) |=> irq_o)
		else $error("modem status interrupt missing");
	chk_flag_clear: assert property ((rd_modem && next_cts_n == cts_pin_n && next_dsr_n == dsr_pin_n)
		|=> !dcts && !ddsr)
		else $error("change flags survived a status read");

endmodule

// file: testbench/ump_modem_model.sv
// External modem model: drives the status pins and the serial receive line, listens on transmit.
`timescale 1ns/1ns
module ump_modem_model
(
	input wire logic sys_clk_i,
	input wire logic txd_i,
	output logic rxd_o,
	output logic cts_n_o,
	output logic dsr_n_o
);
	int lows;
	initial
	begin
		rxd_o = 1'b1;
		cts_n_o = 1'b1;
		dsr_n_o = 1'b1;
		lows = 0;
	end
	// Any low on the transmit line is counted so a silent line can be proven.
	always @(posedge sys_clk_i)
		if (txd_i === 1'b0)
			lows <= lows + 1;
	// Frames are sent LSB first with one stop bit, and the line rests high afterwards.
	task automatic send(input logic [7:0] b, input int div);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge sys_clk_i);
			rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (div - 1) @(posedge sys_clk_i);
		end
	endtask
	task automatic recv(output logic [7:0] b, input int div);
		int n;
		n = 0;
		b = 8'h00;
		while (txd_i !== 1'b0 && n < 2000)
		begin
			@(posedge sys_clk_i);
			n++;
		end
		repeat (div / 2) @(posedge sys_clk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (div) @(posedge sys_clk_i);
			b[i] = txd_i;
		end
	endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the modem-pin serial port.
`timescale 1ns/1ns
`include "ump_defs.svh"
module tb_top;
	logic clk, rstn, rd_r, wr_r, rxd, txd, rts_n, dtr_n, cts_n, dsr_n, irq, wreq;
	logic [2:0] addr;
	logic [31:0] wdata, rdata;
	logic [7:0] seed, b, got;
	logic [31:0] exp_q[$];
	int fails, tests_run, cyc;
	ump_uart_core DUT (.sys_clk_i(clk), .rstn_i(rstn), .avs_address_i(addr), .avs_read_i(rd_r),
		.avs_write_i(wr_r), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.rxd_i(rxd), .txd_o(txd), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
		.irq_o(irq));
	ump_modem_model modem (.sys_clk_i(clk), .txd_i(txd), .rxd_o(rxd), .cts_n_o(cts_n), .dsr_n_o(dsr_n));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// The request is held until waitrequest is seen low at a rising edge, then released.
	task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_r <= !w;
		wr_r <= w;
		wdata <= d;
		do @(posedge clk); while (wreq !== 1'b0);
		rd_r <= 1'b0;
		wr_r <= 1'b0;
	endtask
	task rd(input logic [2:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
		if (rd_r === 1'b1 && wreq === 1'b0 && exp_q.size() > 0)
			check(rdata, exp_q.pop_front());
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rd_r, wr_r, addr, wdata, rstn, fails, tests_run, cyc} = '0;
		seed = 8'h09;
		repeat (12) @(posedge clk);
		check(txd, 1'b1);
		check(rts_n, 1'b1);
		check(dtr_n, 1'b1);
		rstn <= 1'b1;
		rd(`UMP_REG_LINE_CTRL, 32'h1);
		rd(`UMP_REG_DIVISOR, 32'hae);
		rd(`UMP_REG_INT_EN, 32'h0);
		rd(`UMP_REG_MODEM_STAT, 32'h0);
		bus(1'b1, 3'h7, 32'hffffffff);
		rd(3'h7, 32'h0);
		$display("reset values done");
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, `UMP_REG_MODEM_CTRL, i);
			repeat (2) @(posedge clk);
			check(rts_n, !i[1]);
			check(dtr_n, !i[0]);
		end
		rstn <= 1'b0;
		@(negedge clk);
		check(rts_n, 1'b1);
		check(dtr_n, 1'b1);
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		$display("modem control done");
		bus(1'b1, `UMP_REG_INT_EN, 32'h8);
		modem.cts_n_o <= 1'b0;
		repeat (6) @(posedge clk);
		check(irq, 1'b1);
		rd(`UMP_REG_MODEM_STAT, 32'h11);
		rd(`UMP_REG_MODEM_STAT, 32'h10);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		modem.dsr_n_o <= 1'b0;
		repeat (6) @(posedge clk);
		check(irq, 1'b1);
		rd(`UMP_REG_MODEM_STAT, 32'h32);
		bus(1'b1, `UMP_REG_INT_EN, 32'h0);
		modem.cts_n_o <= 1'b1;
		modem.dsr_n_o <= 1'b1;
		repeat (6) @(posedge clk);
		check(irq, 1'b0);
		rd(`UMP_REG_MODEM_STAT, 32'h03);
		$display("modem status done");
		bus(1'b1, `UMP_REG_DIVISOR, 32'h4);
		seed = lfsr(seed);
		b = seed;
		fork
			bus(1'b1, `UMP_REG_DATA, {24'h0, b});
			modem.recv(got, 4);
		join
		check(got, b);
		seed = lfsr(seed);
		modem.send(seed, 4);
		repeat (20) @(posedge clk);
		rd(`UMP_REG_LINE_STAT, 32'h61);
		rd(`UMP_REG_DATA, seed);
		bus(1'b1, `UMP_REG_MODEM_CTRL, 32'h10);
		modem.lows = 0;
		seed = lfsr(seed);
		fork
			bus(1'b1, `UMP_REG_DATA, {24'h0, seed});
			modem.send(~seed, 4);
		join
		repeat (60) @(posedge clk);
		check(modem.lows, 32'h0);
		rd(`UMP_REG_DATA, seed);
		$display("serial and loopback done");
		bus(1'b1, `UMP_REG_MODEM_CTRL, 32'h0);
		bus(1'b1, `UMP_REG_LINE_CTRL, 32'h0);
		modem.lows = 0;
		seed = lfsr(seed);
		bus(1'b1, `UMP_REG_DATA, {24'h0, seed});
		repeat (60) @(posedge clk);
		check(modem.lows, 32'h0);
		rd(`UMP_REG_LINE_STAT, 32'h40);
		fork
			bus(1'b1, `UMP_REG_LINE_CTRL, 32'h1);
			modem.recv(got, 4);
		join
		check(got, seed);
		$display("transmit disable done");
		close_out();
	end
endmodule
